// ==== src/sorting_result_handler_output.sv ====
/*
 * Handler interface driver for the comparator sorting judgment.
 * Software (or the comparator) writes a result word over AXI4-Lite;
 * the block drives the active-low bin, reject and flag lines, the
 * measure-complete and alarm lines, and a beep request.
 * Assumes a single 200 MHz clock and pins that come from another domain.
 */
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`default_nettype none
`include "sorting_cfg.svh"

module sorting_result_handler_output (
    input wire logic CLOCK_I,
    input wire logic NRST_I,
    // AXI4-Lite slave
    input wire logic [7:0] AWADDR_I,
    input wire logic AWVALID_I,
    output logic AWREADY_O,
    input wire logic [31:0] WDATA_I,
    input wire logic [3:0] WSTRB_I,
    input wire logic WVALID_I,
    output logic WREADY_O,
    output logic [1:0] BRESP_O,
    output logic BVALID_O,
    input wire logic BREADY_I,
    input wire logic [7:0] ARADDR_I,
    input wire logic ARVALID_I,
    output logic ARREADY_O,
    output logic [31:0] RDATA_O,
    output logic [1:0] RRESP_O,
    output logic RVALID_O,
    input wire logic RREADY_I,
    // Handler pins, active low except the trigger input, which acts on its rising edge
    input wire logic EXTERNAL_TRIGGER_IN_I,
    input wire logic KEY_LOCK_N_I,
    output logic [8:0] SORT_BIN_N_O,
    output logic ALL_BINS_REJECT_N_O,
    output logic SECONDARY_FAIL_N_O,
    output logic AUX_BIN_N_O,
    output logic PRIMARY_BELOW_LIMIT_N_O,
    output logic PRIMARY_ABOVE_LIMIT_N_O,
    output logic OVERLOAD_FLAG_N_O,
    output logic LOW_CAP_OR_NO_CONTACT_N_O,
    output logic INDEX_N_O,
    output logic MEASURE_COMPLETE_N_O,
    output logic ALARM_N_O,
    // Internal side
    output logic MEAS_START_O,
    output logic KEY_LOCK_O,
    output logic BEEP_O,
    output logic IRQ_O
);
    import sorting_pkg::*;

    // Software state
    logic [31:0] ctrl; // Control word
    logic [31:0] result; // Latest judgment word
    logic [`EV_W-1:0] status; // Sticky events
    logic [`EV_W-1:0] mask; // Interrupt enables
    logic new_result; // One-cycle pulse on a result write

    // Pin synchronisers
    logic [1:0] trig_sync; // Trigger, two flops
    logic [1:0] lock_sync; // Key lock, two flops
    logic trig_prev; // Last synced trigger level

    // Bus handshake
    wr_state_t wr_state;
    logic aw_got; // Address taken
    logic w_got; // Data taken
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // Beep timer
    logic [15:0] beep_cnt;

    // Control field decode
    wire cmp_on = ctrl[`CTRL_CMP_ON];
    wire aux_on = ctrl[`CTRL_AUX_ON];
    wire sec_on = ctrl[`CTRL_SEC_ON];
    wire ext_mode = ctrl[`CTRL_EXTERNAL_TRIGGER_IN];
    wire beep_mode_t beep_mode = beep_mode_t'(ctrl[`CTRL_BEEP_HI:`CTRL_BEEP_LO]);

    // Result field decode
    wire bin_code_t bin = result[`RES_BIN_HI:`RES_BIN_LO];
    wire pri_below = result[`RES_PRI_BELOW];
    wire pri_above = result[`RES_PRI_ABOVE];
    wire sec_fail = result[`RES_SEC_FAIL];
    wire overload_flag = result[`RES_OVERLOAD_FLAG];
    wire lowc = result[`RES_LOWC];
    wire meas_err = result[`RES_ERROR];

    // Judgment classification
    wire in_bin = (bin >= 4'h1) && (bin <= 4'h9);
    wire sec_rej = in_bin && sec_on && sec_fail;
    wire pass = in_bin && !sec_rej && !overload_flag;
    wire out_rej = !overload_flag && (!in_bin || (sec_rej && !aux_on));
    wire aux_rej = !overload_flag && sec_rej && aux_on;

    // Next handler line levels (active high here, inverted at the flops)
    logic [8:0] next_bins;
    always_comb begin
        next_bins = 9'h000;
        // One bin line only, and only on a pass (bin 1 to 9, no secondary reject, no overload; low-C and error still sort)
        if (pass) begin
            next_bins[bin - 4'h1] = 1'b1;
        end
    end
    wire next_out = cmp_on && out_rej;
    wire next_aux = cmp_on && aux_rej;
    wire next_secondary_fail = cmp_on && sec_rej && !overload_flag;
    wire next_plo = cmp_on && !overload_flag && !in_bin && pri_below;
    wire next_phi = cmp_on && !overload_flag && !in_bin && pri_above;
    wire next_overload_flag = cmp_on && overload_flag;
    wire next_lowc = cmp_on && lowc;
    wire next_alarm = cmp_on && meas_err;

    // Beep condition
    wire reject = out_rej || aux_rej || overload_flag || lowc;
    wire beep_hit = new_result && (((beep_mode == BEEP_REJECT) && reject) ||
                    ((beep_mode == BEEP_PASS) && pass));

    // Synced trigger rising edge
    wire trig_rise = trig_sync[1] && !trig_prev;
    wire start = ext_mode && trig_rise;

    // Bus decode
    // Taken only at an edge where valid and ready are both high
    wire aw_take = AWVALID_I && AWREADY_O && !aw_got && (wr_state == WR_IDLE);
    wire w_take = WVALID_I && WREADY_O && !w_got && (wr_state == WR_IDLE);
    wire wr_fire = (wr_state == WR_RESP);
    wire wr_ctrl = wr_fire && (aw_addr == `REG_CTRL_OFS);
    wire wr_res = wr_fire && (aw_addr == `REG_RESULT_OFS);
    wire wr_stat = wr_fire && (aw_addr == `REG_STATUS_OFS);
    wire wr_mask = wr_fire && (aw_addr == `REG_MASK_OFS);
    wire wr_known = wr_ctrl || wr_res || wr_stat || wr_mask;
    wire [31:0] bytemask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
    wire rd_take = ARVALID_I && !RVALID_O;
    wire rd_known = (ARADDR_I == `REG_CTRL_OFS) || (ARADDR_I == `REG_RESULT_OFS) ||
                    (ARADDR_I == `REG_STATUS_OFS) || (ARADDR_I == `REG_MASK_OFS) ||
                    (ARADDR_I == `REG_INPUT_OFS);
    logic [31:0] rd_data;
    always_comb begin
        unique case (ARADDR_I)
            `REG_CTRL_OFS: rd_data = ctrl;
            `REG_RESULT_OFS: rd_data = result;
            `REG_STATUS_OFS: rd_data = {28'h0, status};
            `REG_MASK_OFS: rd_data = {28'h0, mask};
            `REG_INPUT_OFS: rd_data = {30'h0, lock_sync[1], trig_sync[1]};
            default: rd_data = 32'h0;
        endcase
    end

    // Events: done, trigger, alarm, beep
    wire [`EV_W-1:0] events = {beep_hit, new_result && next_alarm, start, new_result};
    wire [`EV_W-1:0] next_status = (status & ~(wr_stat ? w_data[`EV_W-1:0] : 4'h0)) | events;

    // Pin synchronisers; first stage feeds only the second
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            trig_sync <= 2'b00;
            lock_sync <= 2'b11;
            trig_prev <= 1'b0;
        end else begin
            trig_sync <= {trig_sync[0], EXTERNAL_TRIGGER_IN_I};
            lock_sync <= {lock_sync[0], KEY_LOCK_N_I};
            trig_prev <= trig_sync[1];
        end
    end

    // Write channel handshake; address and data in either order
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            wr_state <= WR_IDLE;
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            BVALID_O <= 1'b0;
            BRESP_O <= 2'b00;
        end else begin
            unique case (wr_state)
                WR_IDLE: begin
                    if (aw_take) begin
                        aw_got <= 1'b1;
                        aw_addr <= AWADDR_I;
                    end
                    if (w_take) begin
                        w_got <= 1'b1;
                        w_data <= WDATA_I;
                        w_strb <= WSTRB_I;
                    end
                    if ((aw_got || aw_take) && (w_got || w_take)) begin
                        wr_state <= WR_RESP;
                    end
                end
                WR_RESP: begin
                    // Register updated this cycle, answer next
                    BVALID_O <= 1'b1;
                    BRESP_O <= wr_known ? 2'b00 : 2'b10;
                    wr_state <= WR_WAIT;
                end
                WR_WAIT: begin
                    if (BREADY_I) begin
                        BVALID_O <= 1'b0;
                        aw_got <= 1'b0;
                        w_got <= 1'b0;
                        wr_state <= WR_IDLE;
                    end
                end
            endcase
        end
    end

    // Ready rises one cycle after valid is seen and drops on the take
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            AWREADY_O <= 1'b0;
            WREADY_O <= 1'b0;
        end else begin
            AWREADY_O <= AWVALID_I && !aw_got && (wr_state == WR_IDLE) && !AWREADY_O;
            WREADY_O <= WVALID_I && !w_got && (wr_state == WR_IDLE) && !WREADY_O;
        end
    end

    // Read channel: one-cycle answer
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ARREADY_O <= 1'b0;
            RVALID_O <= 1'b0;
            RDATA_O <= 32'h0;
            RRESP_O <= 2'b00;
        end else begin
            ARREADY_O <= rd_take && !ARREADY_O;
            if (ARREADY_O) begin
                RVALID_O <= 1'b1;
                RDATA_O <= rd_data;
                RRESP_O <= rd_known ? 2'b00 : 2'b10;
            end else if (RREADY_I) begin
                RVALID_O <= 1'b0;
            end
        end
    end

    // Software registers; byte strobes honoured for control and result, not for mask or status
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ctrl <= `CTRL_RESET;
            result <= 32'h0;
            mask <= 4'h0;
            status <= 4'h0;
            new_result <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl <= (ctrl & ~bytemask) | (w_data & bytemask);
            if (wr_res) result <= (result & ~bytemask) | (w_data & bytemask);
            if (wr_mask) mask <= w_data[`EV_W-1:0];
            new_result <= wr_res;
            // Set wins over write-one-to-clear
            status <= next_status;
        end
    end

    // Handler lines; off-state forces judgment high and index/complete low
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            SORT_BIN_N_O <= 9'h1ff;
            ALL_BINS_REJECT_N_O <= 1'b1;
            SECONDARY_FAIL_N_O <= 1'b1;
            AUX_BIN_N_O <= 1'b1;
            PRIMARY_BELOW_LIMIT_N_O <= 1'b1;
            PRIMARY_ABOVE_LIMIT_N_O <= 1'b1;
            OVERLOAD_FLAG_N_O <= 1'b1;
            LOW_CAP_OR_NO_CONTACT_N_O <= 1'b1;
            INDEX_N_O <= 1'b0;
            MEASURE_COMPLETE_N_O <= 1'b0;
            ALARM_N_O <= 1'b1;
        end else if (!cmp_on) begin
            SORT_BIN_N_O <= 9'h1ff;
            ALL_BINS_REJECT_N_O <= 1'b1;
            SECONDARY_FAIL_N_O <= 1'b1;
            AUX_BIN_N_O <= 1'b1;
            PRIMARY_BELOW_LIMIT_N_O <= 1'b1;
            PRIMARY_ABOVE_LIMIT_N_O <= 1'b1;
            OVERLOAD_FLAG_N_O <= 1'b1;
            LOW_CAP_OR_NO_CONTACT_N_O <= 1'b1;
            INDEX_N_O <= 1'b0;
            MEASURE_COMPLETE_N_O <= 1'b0;
            ALARM_N_O <= 1'b1;
        end else if (start) begin
            // New measurement: complete and index go inactive
            INDEX_N_O <= 1'b1;
            MEASURE_COMPLETE_N_O <= 1'b1;
        end else if (new_result) begin
            SORT_BIN_N_O <= ~(next_bins & {9{cmp_on}});
            ALL_BINS_REJECT_N_O <= !next_out;
            SECONDARY_FAIL_N_O <= !next_secondary_fail;
            AUX_BIN_N_O <= !next_aux;
            PRIMARY_BELOW_LIMIT_N_O <= !next_plo;
            PRIMARY_ABOVE_LIMIT_N_O <= !next_phi;
            OVERLOAD_FLAG_N_O <= !next_overload_flag;
            LOW_CAP_OR_NO_CONTACT_N_O <= !next_lowc;
            ALARM_N_O <= !next_alarm;
            INDEX_N_O <= 1'b0;
            MEASURE_COMPLETE_N_O <= 1'b0;
        end
    end

    // Internal outputs: start pulse, lock level, beep, interrupt
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            MEAS_START_O <= 1'b0;
            KEY_LOCK_O <= 1'b0;
            BEEP_O <= 1'b0;
            beep_cnt <= 16'h0;
            IRQ_O <= 1'b0;
        end else begin
            MEAS_START_O <= start;
            KEY_LOCK_O <= !lock_sync[1];
            if (beep_hit) begin
                beep_cnt <= 16'(`BEEP_CYC);
            end else if (beep_cnt != 16'h0) begin
                beep_cnt <= beep_cnt - 16'h1;
            end
            BEEP_O <= beep_hit || (beep_cnt > 16'h1);
            IRQ_O <= |(next_status & mask);
        end
    end

endmodule : sorting_result_handler_output

`default_nettype wire

// ==== include/sorting_cfg.svh ====
/*
 * Constants for the handler sorting output block: register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef SORTING_CFG_SVH
`define SORTING_CFG_SVH

// Register byte offsets
`define REG_CTRL_OFS 8'h00
`define REG_RESULT_OFS 8'h04
`define REG_STATUS_OFS 8'h08
`define REG_MASK_OFS 8'h0c
`define REG_INPUT_OFS 8'h10

// Control fields
`define CTRL_CMP_ON 0
`define CTRL_AUX_ON 1
`define CTRL_SEC_ON 2
`define CTRL_EXTERNAL_TRIGGER_IN 3
`define CTRL_BEEP_LO 4
`define CTRL_BEEP_HI 5
`define CTRL_RESET 32'h0000_0000

// Result fields (written by the comparator side)
`define RES_BIN_LO 0
`define RES_BIN_HI 3
`define RES_PRI_BELOW 4
`define RES_PRI_ABOVE 5
`define RES_SEC_FAIL 6
`define RES_OVERLOAD_FLAG 7
`define RES_LOWC 8
`define RES_ERROR 9
`define RES_START 31

// Status event bits
`define EV_DONE 0
`define EV_TRIG 1
`define EV_ALARM 2
`define EV_BEEP 3
`define EV_W 4

// Beep pulse length
`define BEEP_NS 1000
`define CLK_NS 5
`define BEEP_CYC ((`BEEP_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ==== include/sorting_pkg.sv ====
/*
 * Types for the handler sorting output block.
 * Assumes sorting_cfg.svh is on the include path.
 */
`default_nettype none

package sorting_pkg;
    // Beep condition selection
    typedef enum logic [1:0] {
        BEEP_OFF = 2'h0,
        BEEP_REJECT = 2'h1,
        BEEP_PASS = 2'h2
    } beep_mode_t;

    // Bus write handshake states, one-hot
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_RESP = 3'b010,
        WR_WAIT = 3'b100
    } wr_state_t;

    typedef logic [3:0] bin_code_t;
endpackage : sorting_pkg

`default_nettype wire

// ==== verif/sorting_result_checker.sv ====
/* Assertion checker for the handler sorting output block.
   Assumes one clock and an active-low asynchronous reset. */
`default_nettype none
module sorting_result_checker (
    input wire logic CLOCK_I,
    input wire logic NRST_I,
    input wire logic KEY_LOCK_N_I,
    input wire logic [8:0] SORT_BIN_N_O,
    input wire logic ALL_BINS_REJECT_N_O,
    input wire logic SECONDARY_FAIL_N_O,
    input wire logic AUX_BIN_N_O,
    input wire logic PRIMARY_BELOW_LIMIT_N_O,
    input wire logic PRIMARY_ABOVE_LIMIT_N_O,
    input wire logic OVERLOAD_FLAG_N_O,
    input wire logic INDEX_N_O,
    input wire logic MEASURE_COMPLETE_N_O,
    input wire logic MEAS_START_O,
    input wire logic KEY_LOCK_O,
    input wire logic BEEP_O
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!NRST_I);
    property p_one_sort;
        $countones({~SORT_BIN_N_O, ~ALL_BINS_REJECT_N_O, ~AUX_BIN_N_O}) <= 1;
    endproperty
    a_one_sort: assert property (p_one_sort) else $error("two sort lines low");
    property p_ovl;
        !OVERLOAD_FLAG_N_O |-> (&SORT_BIN_N_O) && ALL_BINS_REJECT_N_O && AUX_BIN_N_O;
    endproperty
    a_ovl: assert property (p_ovl) else $error("sorted on overload");
    property p_limit;
        !(PRIMARY_BELOW_LIMIT_N_O && PRIMARY_ABOVE_LIMIT_N_O) |-> !ALL_BINS_REJECT_N_O;
    endproperty
    a_limit: assert property (p_limit) else $error("limit flag without reject");
    property p_aux;
        !AUX_BIN_N_O |-> !SECONDARY_FAIL_N_O;
    endproperty
    a_aux: assert property (p_aux) else $error("aux bin without secondary fail");
    // Index and complete move together in this design
    property p_idx;
        INDEX_N_O == MEASURE_COMPLETE_N_O;
    endproperty
    a_idx: assert property (p_idx) else $error("index and complete differ");
    property p_start;
        MEAS_START_O |=> !MEAS_START_O;
    endproperty
    a_start: assert property (p_start) else $error("start pulse too long");
    // Six cycles covers the pin synchroniser
    property p_lock;
        (!KEY_LOCK_N_I)[*6] |-> KEY_LOCK_O;
    endproperty
    a_lock: assert property (p_lock) else $error("lock input ignored");
    property p_beep;
        $rose(BEEP_O) |-> BEEP_O[*8];
    endproperty
    a_beep: assert property (p_beep) else $error("beep too short");
endmodule : sorting_result_checker

bind sorting_result_handler_output sorting_result_checker chk (.CLOCK_I(CLOCK_I),
    .NRST_I(NRST_I), .KEY_LOCK_N_I(KEY_LOCK_N_I), .SORT_BIN_N_O(SORT_BIN_N_O),
    .ALL_BINS_REJECT_N_O(ALL_BINS_REJECT_N_O), .SECONDARY_FAIL_N_O(SECONDARY_FAIL_N_O),
    .AUX_BIN_N_O(AUX_BIN_N_O), .PRIMARY_BELOW_LIMIT_N_O(PRIMARY_BELOW_LIMIT_N_O),
    .PRIMARY_ABOVE_LIMIT_N_O(PRIMARY_ABOVE_LIMIT_N_O), .OVERLOAD_FLAG_N_O(OVERLOAD_FLAG_N_O),
    .INDEX_N_O(INDEX_N_O), .MEASURE_COMPLETE_N_O(MEASURE_COMPLETE_N_O),
    .MEAS_START_O(MEAS_START_O), .KEY_LOCK_O(KEY_LOCK_O), .BEEP_O(BEEP_O));
`default_nettype wire

// ==== verif/handler_model.sv ====
/* Handler machine model: drives trigger pulses, short or long.
   Assumes the bench clock and a one-cycle go request. */
`default_nettype none
module handler_model (
    input wire logic clock_i,
    input wire logic go_i,
    input wire logic slow_i,
    output logic trig_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int left = 0; // Pulse cycles still to drive
    // Pin rests low between pulses, like a grounded unused input
    always @(posedge clock_i) begin
        if (go_i) begin
            left <= slow_i ? 8 : 2;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end
    assign trig_o = (left > 0);
endmodule : handler_model
`default_nettype wire

// ==== verif/test_sorting_result_handler_output.sv ====
/* Self-checking bench for the handler sorting output block.
   Assumes the design, checker and handler model are compiled first. */
`default_nettype none
module test_sorting_result_handler_output;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, go = 1'b0, lock_n = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [3:0] wstrb = 4'hf;
    logic [31:0] wdata = 32'h0, lfsr = 32'hb4f479a2;
    wire logic awready, wready, bvalid, arready, rvalid, trig, idx_n, eom_n, alarm_n;
    wire logic sec_n, aux_n, all_n, blw_n, abv_n, ovl_n, lc_n, start, locked, beep, irq;
    wire logic [8:0] bins_n;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    logic [33:0] rq[$]; // Expected read answers, oldest first
    logic [1:0] bq[$]; // Expected write responses, oldest first
    int err_count = 0;
    int compares = 0;
    // Judgment lines turned active high: bins, reject, secondary, aux, limits, flags
    wire logic [15:0] pins = ~{bins_n, all_n, sec_n, aux_n, blw_n, abv_n, ovl_n, lc_n};

    always #2.5 clk = ~clk;

    sorting_result_handler_output dut (.CLOCK_I(clk), .NRST_I(nrst), .AWADDR_I(awaddr),
        .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(wstrb),
        .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp), .BVALID_O(bvalid),
        .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid), .ARREADY_O(arready),
        .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
        .EXTERNAL_TRIGGER_IN_I(trig), .KEY_LOCK_N_I(lock_n), .SORT_BIN_N_O(bins_n),
        .ALL_BINS_REJECT_N_O(all_n), .SECONDARY_FAIL_N_O(sec_n), .AUX_BIN_N_O(aux_n),
        .PRIMARY_BELOW_LIMIT_N_O(blw_n), .PRIMARY_ABOVE_LIMIT_N_O(abv_n),
        .OVERLOAD_FLAG_N_O(ovl_n), .LOW_CAP_OR_NO_CONTACT_N_O(lc_n), .INDEX_N_O(idx_n),
        .MEASURE_COMPLETE_N_O(eom_n), .ALARM_N_O(alarm_n), .MEAS_START_O(start),
        .KEY_LOCK_O(locked), .BEEP_O(beep), .IRQ_O(irq));

    handler_model hm (.clock_i(clk), .go_i(go), .slow_i(lfsr[0]), .trig_o(trig));

    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction : nxt

    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    // Starts one edge late so no strobe is driven twice in a time step
    // Waits for the answer however long it takes; only the watchdog ends a hang
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bq.push_back((a == 8'h00 || a == 8'h04 || a == 8'h08 || a == 8'h0c) ? 2'b00 : 2'b10);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [33:0] exp);
        @(posedge clk);
        rq.push_back(exp);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask : rd

    // Outputs follow a result write two cycles later; three leaves margin
    task automatic put(input logic [31:0] c, input logic [31:0] r, input logic [15:0] e);
        wr(8'h00, c);
        wr(8'h04, r);
        cyc(3);
        chk("pins", e, pins);
    endtask : put

    task automatic see(input int n, input bit sel, output logic s);
        s = 1'b0;
        repeat (n) begin
            @(posedge clk);
            if ((sel ? start : beep) === 1'b1) s = 1'b1;
        end
    endtask : see

    task automatic wrap_up;
        $display("counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // Read answers checked in the order they were requested
    always @(posedge clk) begin
        if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0) begin
            chk("rdata", rq.pop_front(), {rresp, rdata});
        end
        // Write responses checked as they are accepted
        if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0) begin
            chk("bresp", bq.pop_front(), bresp);
        end
    end

    // Whole run needs under two thousand cycles
    initial begin
        cyc(20000);
        err_count++;
        wrap_up();
    end

    initial begin
        logic s;
        int b;
        cyc(8);
        nrst <= 1'b1;
        cyc(1);
        chk("idle", 34'h0, {pins, idx_n, eom_n});
        rd(8'h00, 34'h0);
        rd(8'h14, {2'b10, 32'h0});
        wr(8'h10, 32'h0);
        put(32'h0, 32'h3, 16'h0);
        chk("index", 2'b00, {idx_n, eom_n});
        for (b = 1; b <= 9; b++) put(32'h1, b, 16'h1 << (6 + b));
        put(32'h1, 32'h10, 16'h48);
        put(32'h1, 32'h20, 16'h44);
        put(32'h1, 32'h85, 16'h02);
        put(32'h1, 32'h102, 16'h101);
        put(32'h5, 32'h44, 16'h60);
        put(32'h7, 32'h44, 16'h30);
        repeat (4) begin
            lfsr = nxt(lfsr);
            b = lfsr % 9 + 1;
            put(32'h1, b, 16'h1 << (6 + b));
        end
        put(32'h1, 32'h205, 16'h800);
        chk("alarm", 1'b0, alarm_n);
        $display("test done: judgment");
        wr(8'h08, 32'hf);
        wr(8'h0c, 32'h1);
        put(32'h1, 32'h1, 16'h80);
        chk("irq", 1'b1, irq);
        rd(8'h08, 34'h1);
        wr(8'h08, 32'h1);
        cyc(2);
        chk("irq", 1'b0, irq);
        $display("test done: interrupt");
        for (b = 0; b < 2; b++) begin
            wr(8'h00, 32'h1 | (b << 3));
            go <= 1'b1;
            cyc(1);
            go <= 1'b0;
            see(14, 1'b1, s);
            chk("start", b, s);
            chk("complete", {2{b[0]}}, {idx_n, eom_n});
            lock_n <= 1'b0;
            cyc(8);
            chk("lock", 1'b1, locked);
            rd(8'h10, 34'h0);
            lock_n <= 1'b1;
            cyc(8);
            chk("lock", 1'b0, locked);
        end
        $display("test done: trigger and lock");
        for (b = 0; b < 3; b++) begin
            wr(8'h00, 32'h1 | (b << 4));
            wr(8'h04, 32'h10);
            see(10, 1'b0, s);
            chk("beep", b == 1, s);
            cyc(210);
            wr(8'h04, 32'h3);
            see(10, 1'b0, s);
            chk("beep", b == 2, s);
            cyc(210);
        end
        $display("test done: beep");
        wrap_up();
    end
endmodule : test_sorting_result_handler_output
`default_nettype wire
